// ---- src/amd_pkg.sv ----
// package: constants and types for the addressing mode decoder
// Notes on behaviour
// - The x_to_stack_pointer opcode loads the stack pointer with X minus one in three bus cycles.
// - The prebyted y_to_stack_pointer opcode loads the stack pointer with Y minus one in four bus cycles.
// - The wait_for_interrupt_op stacks for twelve cycles, idles until an interrupt, then takes two vector cycles.
// - Direct mode takes one address byte as the low byte with a zero high byte.
// - Indexed mode adds an unsigned offset byte to X or Y to form the effective_address.
// - A branch always adds the sign-extended offset to the following address, and loads the pc with the sum only when its condition holds.
// - Immediate operands follow the opcode, and a 16-bit one arrives high byte first.
// - Extended mode reads a 16-bit effective_address high byte first from the bytes after the opcode.
// - Certain first bytes are prebytes that move decode of the next opcode to pages two, three or four.
// - Inherent opcodes fetch no operand bytes and are one byte long, two with a prebyte.
// - Bit-manipulation opcodes use a mask whose set bits pick the operand bits affected.
package amd_pkg;
   localparam logic [7:0]  PRE_PAGE2   = 8'h18;
   localparam logic [7:0]  PRE_PAGE3   = 8'h1A;
   localparam logic [7:0]  PRE_PAGE4   = 8'hCD;
   localparam logic [7:0]  OP_TXS_TYS  = 8'h35;
   localparam logic [7:0]  OP_WAIT     = 8'h3E;
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic [15:0] SP_RESET    = 16'h0000;
   localparam logic [3:0]  XFER_CYC_X  = 4'h3;
   localparam logic [3:0]  XFER_CYC_Y  = 4'h4;
   localparam logic [3:0]  WAIT_STACK  = 4'hC;
   localparam logic [3:0]  WAIT_VECTOR = 4'h2;
   localparam logic [15:0] WAIT_VEC_AD = 16'hFFF2;

   typedef enum logic [3:0] {
      AMD_INH = 4'h1,
      AMD_IMM = 4'h2,
      AMD_DIR = 4'h3,
      AMD_EXT = 4'h4,
      AMD_IDX = 4'h5,
      AMD_REL = 4'h6,
      AMD_BIT = 4'h7
   } amd_mode_t;
endpackage : amd_pkg

// ---- src/amd_dec_if.sv ----
// interface: opcode to decode result between core and table
interface amd_dec_if;
   logic [1:0]         page;
   logic [7:0]         opcode;
   amd_pkg::amd_mode_t mode;
   logic               use_y;
   logic               imm16;
   logic               is_pre;
   logic               bit_op;
   logic               bit_branch;
   modport core (output page, output opcode, input mode, input use_y, input imm16, input is_pre,
                 input bit_op, input bit_branch);
   modport table_side (input page, input opcode, output mode, output use_y, output imm16, output is_pre,
                       output bit_op, output bit_branch);
endinterface : amd_dec_if

// ---- src/amd_decode_table.sv ----
// module: combinational opcode page and addressing mode table
module amd_decode_table (
   amd_dec_if.table_side d
);
   logic [3:0] hi;
   logic [3:0] lo;
   assign hi = d.opcode[7:4];
   assign lo = d.opcode[3:0];

   // mode from column, page and prebyte detection
   always_comb begin
      d.mode       = amd_pkg::AMD_INH;
      d.use_y      = (d.page != 2'd0) && (d.page != 2'd2);
      d.imm16      = 1'b0;
      d.is_pre     = 1'b0;
      d.bit_op     = 1'b0;
      d.bit_branch = 1'b0;
      if (d.page == 2'd0 && (d.opcode == amd_pkg::PRE_PAGE2 || d.opcode == amd_pkg::PRE_PAGE3 ||
                             d.opcode == amd_pkg::PRE_PAGE4)) begin
         d.is_pre = 1'b1;
      end else if (hi == 4'h1 && lo >= 4'h2 && lo <= 4'h5 || hi == 4'h1 && lo >= 4'hC) begin
         d.bit_op     = 1'b1;
         d.bit_branch = (lo == 4'h2) || (lo == 4'h3) || (lo >= 4'hE);
         d.mode       = (lo == 4'h2 || lo == 4'h3 || lo == 4'h4 || lo == 4'h5) ? amd_pkg::AMD_DIR
                                                                              : amd_pkg::AMD_IDX;
      end else if (hi == 4'h2 || d.opcode == 8'h8D) begin
         d.mode = amd_pkg::AMD_REL;
      end else if (hi == 4'h6 || hi == 4'hA || hi == 4'hE) begin
         d.mode = amd_pkg::AMD_IDX;
      end else if (hi == 4'h7 || hi == 4'hB || hi == 4'hF) begin
         d.mode = amd_pkg::AMD_EXT;
      end else if (hi == 4'h9 || hi == 4'hD) begin
         d.mode = amd_pkg::AMD_DIR;
      end else if ((hi == 4'h8 || hi == 4'hC) && lo != 4'hF && d.opcode != 8'hCD) begin
         d.mode  = amd_pkg::AMD_IMM;
         d.imm16 = (lo == 4'h3) || (lo == 4'hC) || (lo == 4'hE);
      end
   end
endmodule : amd_decode_table

// ---- src/amd_core.sv ----
// module: instruction fetch, addressing mode sequencing and stack transfers
module amd_core #(
   parameter int unsigned FETCH_LAT = 1
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_rdata,
   input  wire logic [15:0] i_x_reg,
   input  wire logic [15:0] i_y_reg,
   input  wire logic        i_irq,
   input  wire logic        i_branch_taken,
   output logic      [15:0] o_addr,
   output logic             o_fetch,
   output logic      [15:0] o_pc,
   output logic      [15:0] o_sp,
   output logic      [15:0] o_effective_address,
   output logic      [15:0] o_operand,
   output logic      [7:0]  o_mask,
   output logic      [3:0]  o_mode,
   output logic             o_done,
   output logic             o_waiting
);
   typedef enum logic [7:0] {
      ST_OPC  = 8'h01,
      ST_OPR1 = 8'h02,
      ST_OPR2 = 8'h04,
      ST_MASK = 8'h08,
      ST_REL  = 8'h10,
      ST_EXEC = 8'h20,
      ST_IDLE = 8'h40,
      ST_VEC  = 8'h80
   } amd_state_t;

   amd_dec_if dec ();
   amd_decode_table u_table (.d(dec));

   amd_state_t         st_q, st_d;
   logic [1:0]         page_q, page_d;
   logic [7:0]         opc_q, opc_d;
   logic [15:0]        pc_q, pc_d, sp_q, sp_d, ea_q, ea_d, opr_q, opr_d, addr_q, addr_d;
   logic [7:0]         mask_q, mask_d;
   logic [3:0]         cnt_q, cnt_d, mode_q, mode_d;
   logic               done_q, done_d, wait_q, wait_d;
   logic [15:0]        next_pc;

   assign dec.page   = page_q;
   assign dec.opcode = opc_q;
   assign next_pc    = pc_q + 16'h0001;

   // next state: one byte per fetch cycle, pc steps per byte
   always_comb begin
      st_d   = st_q;
      page_d = page_q;
      opc_d  = opc_q;
      pc_d   = pc_q;
      sp_d   = sp_q;
      ea_d   = ea_q;
      opr_d  = opr_q;
      mask_d = mask_q;
      cnt_d  = cnt_q;
      mode_d = mode_q;
      addr_d = addr_q;
      done_d = 1'b0;
      wait_d = wait_q;
      case (st_q)
         ST_OPC: begin
            opc_d  = i_rdata;
            pc_d   = next_pc;
            addr_d = next_pc;
            cnt_d  = (page_q == 2'd0) ? 4'h1 : cnt_q + 4'h1; // prebyte cycles count toward the total
            st_d   = ST_EXEC;
         end
         ST_EXEC: begin
            mode_d = dec.mode;
            cnt_d  = cnt_q + 4'h1;
            if (dec.is_pre) begin
               page_d = (opc_q == amd_pkg::PRE_PAGE2) ? 2'd1 : (opc_q == amd_pkg::PRE_PAGE3) ? 2'd2 : 2'd3;
               st_d   = ST_OPC;
            end else if (page_q == 2'd0 && opc_q == amd_pkg::OP_WAIT) begin
               if (cnt_q + 4'h1 >= amd_pkg::WAIT_STACK) begin
                  st_d   = ST_IDLE;
                  wait_d = 1'b1;
               end
            end else if (opc_q == amd_pkg::OP_TXS_TYS && (page_q == 2'd0 || page_q == 2'd1)) begin
               if (cnt_q + 4'h1 >= ((page_q == 2'd1) ? amd_pkg::XFER_CYC_Y : amd_pkg::XFER_CYC_X)) begin
                  sp_d   = ((page_q == 2'd1) ? i_y_reg : i_x_reg) - 16'h0001;
                  done_d = 1'b1;
                  page_d = 2'd0;
                  st_d   = ST_OPC;
               end
            end else if (dec.mode == amd_pkg::AMD_INH) begin
               done_d = 1'b1;
               page_d = 2'd0;
               st_d   = ST_OPC;
            end else begin
               st_d = ST_OPR1;
            end
         end
         ST_OPR1: begin
            pc_d   = next_pc;
            addr_d = next_pc;
            opr_d  = {8'h00, i_rdata};
            case (dec.mode)
               amd_pkg::AMD_DIR: ea_d = {8'h00, i_rdata};
               amd_pkg::AMD_IDX: ea_d = (dec.use_y ? i_y_reg : i_x_reg) + {8'h00, i_rdata};
               amd_pkg::AMD_EXT: ea_d = {i_rdata, 8'h00};
               amd_pkg::AMD_REL: ea_d = next_pc + {{8{i_rdata[7]}}, i_rdata};
               default: ea_d = ea_q;
            endcase
            if (dec.mode == amd_pkg::AMD_EXT || (dec.mode == amd_pkg::AMD_IMM && dec.imm16)) begin
               st_d = ST_OPR2;
            end else if (dec.mode == amd_pkg::AMD_REL) begin
               st_d = ST_REL;
            end else if (dec.bit_op) begin
               st_d = ST_MASK;
            end else begin
               done_d = 1'b1;
               page_d = 2'd0;
               st_d   = ST_OPC;
            end
         end
         ST_OPR2: begin
            pc_d   = next_pc;
            addr_d = next_pc;
            if (dec.mode == amd_pkg::AMD_EXT) begin
               ea_d = {ea_q[15:8], i_rdata};
            end else begin
               opr_d = {opr_q[7:0], i_rdata};
            end
            done_d = 1'b1;
            page_d = 2'd0;
            st_d   = ST_OPC;
         end
         ST_MASK: begin
            pc_d   = next_pc;
            addr_d = next_pc;
            mask_d = i_rdata;
            if (dec.bit_branch) begin
               st_d = ST_REL;
               mode_d = amd_pkg::AMD_REL;
            end else begin
               done_d = 1'b1;
               page_d = 2'd0;
               st_d   = ST_OPC;
            end
         end
         ST_REL: begin
            if (dec.bit_branch && mode_q == amd_pkg::AMD_REL) begin
               pc_d = next_pc; // offset byte after the mask
               ea_d = next_pc + {{8{i_rdata[7]}}, i_rdata};
               pc_d = i_branch_taken ? next_pc + {{8{i_rdata[7]}}, i_rdata} : next_pc;
            end else begin
               pc_d = i_branch_taken ? ea_q : pc_q;
            end
            addr_d = pc_d;
            done_d = 1'b1;
            page_d = 2'd0;
            st_d   = ST_OPC;
         end
         ST_IDLE: begin
            if (i_irq) begin
               wait_d = 1'b0;
               cnt_d  = 4'h0;
               addr_d = amd_pkg::WAIT_VEC_AD;
               st_d   = ST_VEC;
            end
         end
         ST_VEC: begin
            cnt_d  = cnt_q + 4'h1;
            addr_d = amd_pkg::WAIT_VEC_AD + 16'h0001;
            if (cnt_q[1:0] == 2'(amd_pkg::WAIT_VECTOR - 4'h1)) begin
               pc_d   = {opr_q[7:0], i_rdata};
               addr_d = {opr_q[7:0], i_rdata};
               done_d = 1'b1;
               st_d   = ST_OPC;
            end else begin
               opr_d = {8'h00, i_rdata};
            end
         end
         default: st_d = ST_OPC;
      endcase
   end

   // state registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q   <= ST_OPC;
         page_q <= 2'd0;
         opc_q  <= 8'h00;
         pc_q   <= amd_pkg::PC_RESET;
         sp_q   <= amd_pkg::SP_RESET;
         ea_q   <= 16'h0000;
         opr_q  <= 16'h0000;
         mask_q <= 8'h00;
         cnt_q  <= 4'h0;
         mode_q <= 4'h0;
         addr_q <= amd_pkg::PC_RESET;
         done_q <= 1'b0;
         wait_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         page_q <= page_d;
         opc_q  <= opc_d;
         pc_q   <= pc_d;
         sp_q   <= sp_d;
         ea_q   <= ea_d;
         opr_q  <= opr_d;
         mask_q <= mask_d;
         cnt_q  <= cnt_d;
         mode_q <= mode_d;
         addr_q <= addr_d;
         done_q <= done_d;
         wait_q <= wait_d;
      end
   end

   assign o_addr              = addr_q;
   assign o_fetch             = 1'b1;
   assign o_pc                = pc_q;
   assign o_sp                = sp_q;
   assign o_effective_address = ea_q;
   assign o_operand           = opr_q;
   assign o_mask              = mask_q;
   assign o_mode              = mode_q;
   assign o_done              = done_q;
   assign o_waiting           = wait_q;
endmodule : amd_core

// ---- verif/amd_mem_model.sv ----
// partner: byte-wide program memory with same-cycle read
module amd_mem_model (
   input  wire logic [15:0] i_addr,
   output logic      [7:0]  o_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:65535];
   // fill with single-byte no-operation opcodes
   initial begin
      foreach (mem[i]) mem[i] = 8'h01;
   end
   // byte at the shown address answers in the same cycle
   assign o_rdata = mem[i_addr];
endmodule : amd_mem_model

// ---- verif/amd_core_sva.sv ----
// checker: timing and address relations at the core ports
module amd_core_sva #(
   parameter int unsigned FETCH_LAT = 1
) (
   input wire logic        i_sys_clk,
   input wire logic        i_resetn,
   input wire logic [15:0] i_x_reg,
   input wire logic [15:0] i_y_reg,
   input wire logic        i_irq,
   input wire logic        o_fetch,
   input wire logic [15:0] o_effective_address,
   input wire logic [3:0]  o_mode,
   input wire logic        o_done,
   input wire logic        o_waiting
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   done_pulse_a: assert property (o_done |=> !o_done) else $error("done held too long");
   fetch_on_a: assert property (o_fetch) else $error("fetch strobe low");
   wait_hold_a: assert property (o_waiting && !i_irq |=> o_waiting) else $error("left wait early");
   wait_exit_a: assert property (o_waiting && i_irq |-> ##[1:3] !o_waiting) else $error("wait not left");
   wait_vector_a: assert property ($fell(o_waiting) |-> ##[1:4] o_done) else $error("vector fetch late");
   wait_nodone_a: assert property (o_waiting |-> !o_done) else $error("done while idle");
   direct_page_a: assert property (o_done && o_mode == amd_pkg::AMD_DIR |-> o_effective_address[15:8] == 8'h00)
      else $error("direct high byte set");
   index_range_a: assert property (o_done && o_mode == amd_pkg::AMD_IDX |->
      (16'(o_effective_address - i_x_reg) <= 16'h00FF) || (16'(o_effective_address - i_y_reg) <= 16'h00FF))
      else $error("indexed address off range");
endmodule : amd_core_sva

bind amd_core amd_core_sva #(.FETCH_LAT(FETCH_LAT)) u_sva (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
   .i_x_reg(i_x_reg), .i_y_reg(i_y_reg), .i_irq(i_irq), .o_fetch(o_fetch),
   .o_effective_address(o_effective_address), .o_mode(o_mode), .o_done(o_done), .o_waiting(o_waiting));

// ---- verif/amd_core_tb.sv ----
// testbench: runs a short program through the decoder core
module amd_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_sys_clk, i_resetn, i_irq, i_branch_taken;
   logic [7:0]  i_rdata, o_mask;
   logic [15:0] i_x_reg, i_y_reg, o_addr, o_pc, o_sp, o_effective_address, o_operand;
   logic [3:0]  o_mode;
   logic        o_fetch, o_done, o_waiting;
   int          err_total, samples_checked;
   logic [7:0]  prog [0:31] = '{8'h01, 8'h35, 8'h18, 8'h35, 8'h96, 8'h40, 8'hA6, 8'h10, 8'h18, 8'hA6, 8'hF0,
      8'hCC, 8'h12, 8'h34, 8'hB6, 8'hAB, 8'hCD, 8'h18, 8'hFE, 8'h56, 8'h78, 8'h14, 8'h40, 8'hC3, 8'h26, 8'h05,
      8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h3E};
   amd_core dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_rdata(i_rdata), .i_x_reg(i_x_reg),
      .i_y_reg(i_y_reg), .i_irq(i_irq), .i_branch_taken(i_branch_taken), .o_addr(o_addr), .o_fetch(o_fetch),
      .o_pc(o_pc), .o_sp(o_sp), .o_effective_address(o_effective_address), .o_operand(o_operand),
      .o_mask(o_mask), .o_mode(o_mode), .o_done(o_done), .o_waiting(o_waiting));
   amd_mem_model mem_u (.i_addr(o_addr), .o_rdata(i_rdata));
   // free-running clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one instruction: cycles to its done pulse and idle cycles seen
   task automatic nxt(output int c, output int w);
      c = 0;
      w = 0;
      do begin
         @(posedge i_sys_clk);
         #1;
         c++;
         if (o_waiting === 1'b1) w++;
         if (w == 5) i_irq = 1'b1;
      end while (o_done !== 1'b1 && c < 300);
      if (o_done !== 1'b1) err_total++; // hung instruction counts as a mismatch
   endtask : nxt
   task automatic ea_chk(input logic [3:0] m, input logic [15:0] ea, input logic [15:0] pc);
      int c, w;
      nxt(c, w);
      chk({12'h000, o_mode}, {12'h000, m});
      chk(o_effective_address, ea);
      chk(o_pc, pc);
   endtask : ea_chk
   task automatic t_xfer;
      int c, w;
      nxt(c, w);
      nxt(c, w);
      chk(o_sp, 16'h1234);
      chk(16'(c), 16'h0003);
      chk(o_pc, 16'h0002);
      nxt(c, w);
      chk(o_sp, 16'h7FFF);
      chk(16'(c), 16'h0004);
      chk(o_pc, 16'h0004);
   endtask : t_xfer
   task automatic t_modes;
      int c, w;
      ea_chk(amd_pkg::AMD_DIR, 16'h0040, 16'h0006);
      ea_chk(amd_pkg::AMD_IDX, 16'h1245, 16'h0008);
      ea_chk(amd_pkg::AMD_IDX, 16'h80F0, 16'h000B);
      nxt(c, w);
      chk(o_operand, 16'h1234);
      chk(o_pc, 16'h000E);
      ea_chk(amd_pkg::AMD_EXT, 16'hABCD, 16'h0011);
      ea_chk(amd_pkg::AMD_EXT, 16'h5678, 16'h0015);
      nxt(c, w);
      chk({8'h00, o_mask}, 16'h00C3);
      chk({12'h000, o_mode}, {12'h000, amd_pkg::AMD_DIR});
      chk(o_effective_address, 16'h0040);
      chk(o_pc, 16'h0018);
   endtask : t_modes
   task automatic t_branch_wait;
      int c, w;
      nxt(c, w);
      chk(o_pc, 16'h001F);
      nxt(c, w);
      chk(16'(c), 16'(14 + w));
      chk(16'(w >= 5), 16'h0001);
      chk(o_pc, 16'h0030);
      i_irq = 1'b0;
      i_branch_taken = 1'b0;
      nxt(c, w);
      chk(o_pc, 16'h0032);
      chk(o_effective_address, 16'h0022);
   endtask : t_branch_wait
   // mid-run reset: outputs clear except o_fetch, which stays high; fetch restarts at address zero
   task automatic t_reset;
      int c, w;
      i_resetn = 1'b0;
      @(posedge i_sys_clk);
      #1;
      chk(o_pc, 16'h0000);
      chk(o_sp, 16'h0000);
      chk(o_addr, 16'h0000);
      chk({15'h0000, o_done}, 16'h0000);
      chk({15'h0000, o_waiting}, 16'h0000);
      chk({15'h0000, o_fetch}, 16'h0001);
      i_resetn = 1'b1;
      nxt(c, w);
      chk(o_pc, 16'h0001);
      chk(16'(c), 16'h0002);
   endtask : t_reset
   task automatic conclude;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   // watchdog against a hung sequence
   initial begin
      #20000;
      err_total++;
      conclude;
   end
   // reset, program load, scenarios
   initial begin
      i_resetn = 1'b0;
      i_x_reg = 16'h1235;
      i_y_reg = 16'h8000;
      i_irq = 1'b0;
      i_branch_taken = 1'b1;
      err_total = 0;
      samples_checked = 0;
      #1;
      foreach (prog[i]) mem_u.mem[i] = prog[i];
      mem_u.mem[16'hFFF2] = 8'h00;
      mem_u.mem[16'hFFF3] = 8'h30;
      mem_u.mem[16'h0030] = 8'h26;
      mem_u.mem[16'h0031] = 8'hF0;
      repeat (5) @(posedge i_sys_clk);
      #1;
      i_resetn = 1'b1;
      t_xfer;
      t_modes;
      t_branch_wait;
      t_reset;
      conclude;
   end
endmodule : amd_core_tb
